// ### logic/flash_cmd_map.vh
// opcode, byte-count and lock-bit constants for the flash command interpreter
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
`define OP_WRITE_ARM 8'h06
`define OP_WRITE_DISARM 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_READ 8'h05
`define OP_PAGE_WRITE 8'h02
`define OP_SMALL_WIPE 8'h20
`define OP_LARGE_WIPE_A 8'h52
`define OP_LARGE_WIPE_B 8'hD8
`define OP_ARRAY_WIPE_A 8'h60
`define OP_ARRAY_WIPE_B 8'hC7
`define OP_PARAM_READ 8'h5A
`define OP_DUAL_READ 8'h3B
`define OP_SIG_READ 8'hAB
`define OP_SLEEP 8'hB9
`define OP_ID_READ 8'h90
`define OP_OTP_OPEN 8'hB1
`define OP_OTP_CLOSE 8'hC1
`define OP_LOCK_READ 8'h2B
`define OP_LOCK_WRITE 8'h2F
`define ADDR_BYTES 3'd3
`define ID_SKIP_BYTES 3'd2
`define LOCK_BIT 1
`endif

// ### logic/byte_fifo.v
// the byte fifo module sits beside the command decoder, so one design file holds all logic

// ### logic/spi_flash_cmd_write_latch.v
// serial command decoder with write latch, otp mode, lock bit and id output
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module spi_flash_cmd_write_latch #(
  parameter [7:0] MAKER_ID = 8'hA5,
  parameter [7:0] PART_ID = 8'h5C,
  parameter FIFO_DEPTH = 8
) (
  input wire clk,
  input wire rst_b,
  input wire selB,
  input wire serClk,
  input wire serIn,
  output reg serOut,
  output reg serOutEn,
  output reg writeLatchBit,
  output reg otpMode,
  output reg lockBit,
  output reg sleepMode,
  output reg [7:0] cmdCode,
  output reg [23:0] cmdAddr,
  output reg cmdPulse,
  output wire [7:0] dataByte,
  output wire dataValid,
  input wire dataReady,
  output wire dataStall
);
  // maker and part id defaults are arbitrary
  localparam [5:0] ST_OP = 6'b000001;
  localparam [5:0] ST_ADDR = 6'b000010;
  localparam [5:0] ST_DUMMY = 6'b000100;
  localparam [5:0] ST_DATA = 6'b001000;
  localparam [5:0] ST_OUT = 6'b010000;
  localparam [5:0] ST_IGNORE = 6'b100000;

  reg [2:0] selSync_r;
  reg [2:0] clkSync_r;
  reg [1:0] inSync_r;
  // select idles high, so its stages reset high and no false frame start follows reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selSync_r <= 3'b111;
    end else begin
      selSync_r <= {selSync_r[1:0], selB};
    end
  end

  // link clock rests low between frames; a low reset keeps a phantom edge away
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkSync_r <= 3'b000;
    end else begin
      clkSync_r <= {clkSync_r[1:0], serClk};
    end
  end

  // data needs only two stages, it is read alongside the second clock stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inSync_r <= 2'b00;
    end else begin
      inSync_r <= {inSync_r[0], serIn};
    end
  end
  // edges judged on stages two and three only, never the first flop
  wire selLow = !selSync_r[1];
  wire selRise = selSync_r[1] && !selSync_r[2];
  wire clkRise = clkSync_r[1] && !clkSync_r[2];
  wire clkFall = !clkSync_r[1] && clkSync_r[2];
  wire bitIn = inSync_r[1];

  reg [5:0] state_r;
  reg [7:0] shift_r;
  reg [2:0] bitCnt_r;
  reg [2:0] byteCnt_r;
  reg [7:0] op_r;
  reg oneByte_r;
  reg idSel_r;
  reg idSecond_r;
  reg [7:0] outShift_r;
  wire [7:0] byteNow = {shift_r[6:0], bitIn};
  wire byteDone = selLow && clkRise && (bitCnt_r == 3'd7);

  wire fifoReady;
  assign dataStall = !fifoReady;
  wire fifoPush = byteDone && state_r == ST_DATA;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) dataFifo (
    .clk(clk),
    .rst_b(rst_b),
    .inData(byteNow),
    .inValid(fifoPush),
    .inReady(fifoReady),
    .outData(dataByte),
    .outValid(dataValid),
    .outReady(dataReady)
  );

  function needsAddr;
    input [7:0] op;
    begin
      needsAddr = op == `OP_PAGE_WRITE || op == `OP_SMALL_WIPE || op == `OP_LARGE_WIPE_A ||
        op == `OP_LARGE_WIPE_B || op == `OP_PARAM_READ || op == `OP_DUAL_READ ||
        op == `OP_ID_READ;
    end
  endfunction

  function knownOp;
    input [7:0] op;
    begin
      knownOp = needsAddr(op) || op == `OP_WRITE_ARM || op == `OP_WRITE_DISARM ||
        op == `OP_STATUS_WRITE || op == `OP_STATUS_READ || op == `OP_ARRAY_WIPE_A ||
        op == `OP_ARRAY_WIPE_B || op == `OP_SIG_READ || op == `OP_SLEEP ||
        op == `OP_OTP_OPEN || op == `OP_OTP_CLOSE || op == `OP_LOCK_READ ||
        op == `OP_LOCK_WRITE;
    end
  endfunction

  wire modOp = op_r == `OP_PAGE_WRITE || op_r == `OP_SMALL_WIPE || op_r == `OP_LARGE_WIPE_A ||
    op_r == `OP_LARGE_WIPE_B || op_r == `OP_ARRAY_WIPE_A || op_r == `OP_ARRAY_WIPE_B ||
    op_r == `OP_STATUS_WRITE;
  // a modifying command completes at select rise, only when armed and byte aligned
  wire cmdEnd = selRise && bitCnt_r == 3'd0 && state_r != ST_IGNORE && state_r != ST_OP;
  wire modDone = cmdEnd && modOp && writeLatchBit &&
    (op_r == `OP_ARRAY_WIPE_A || op_r == `OP_ARRAY_WIPE_B || byteCnt_r == `ADDR_BYTES ||
    state_r == ST_DATA);
  wire oneEnd = selRise && bitCnt_r == 3'd0 && oneByte_r;

  // single-byte commands act only when select rises on the byte edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      writeLatchBit <= 1'b0;
    end else if (modDone) begin
      writeLatchBit <= 1'b0;
    end else if (oneEnd && op_r == `OP_WRITE_ARM) begin
      writeLatchBit <= 1'b1;
    end else if (oneEnd && op_r == `OP_WRITE_DISARM) begin
      writeLatchBit <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otpMode <= 1'b0;
    end else if (oneEnd && op_r == `OP_OTP_OPEN) begin
      otpMode <= 1'b1;
    end else if (oneEnd && op_r == `OP_OTP_CLOSE) begin
      otpMode <= 1'b0;
    end
  end

  // no path clears it, short of a power-on reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockBit <= 1'b0;
    end else if (oneEnd && op_r == `OP_LOCK_WRITE) begin
      lockBit <= 1'b1;
    end
  end

  // wake takes effect at select rise, so the mode never flips inside a frame
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepMode <= 1'b0;
    end else if (oneEnd && op_r == `OP_SLEEP) begin
      sleepMode <= 1'b1;
    end else if (cmdEnd && op_r == `OP_SIG_READ) begin
      sleepMode <= 1'b0;
    end
  end

  // one-clock completion strobe, opcode held for the array engine
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdCode <= 8'h00;
      cmdPulse <= 1'b0;
    end else begin
      cmdPulse <= modDone;
      if (modDone) begin
        cmdCode <= op_r;
      end
    end
  end

  // the pin changes on the falling link edge, a half period before the host samples
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serOut <= 1'b0;
      serOutEn <= 1'b0;
    end else if (!selLow) begin
      serOutEn <= 1'b0;
    end else if (clkFall && state_r == ST_OUT) begin
      serOut <= outShift_r[7];
      serOutEn <= 1'b1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_OP;
      shift_r <= 8'h00;
      bitCnt_r <= 3'd0;
      byteCnt_r <= 3'd0;
      op_r <= 8'h00;
      oneByte_r <= 1'b0;
      idSel_r <= 1'b0;
      idSecond_r <= 1'b0;
      outShift_r <= 8'h00;
      cmdAddr <= 24'h00_0000;
    end else begin
      if (!selLow) begin
        state_r <= ST_OP;
        bitCnt_r <= 3'd0;
        byteCnt_r <= 3'd0;
        oneByte_r <= 1'b0;
      end else begin
        if (clkFall && state_r == ST_OUT) begin
          outShift_r <= {outShift_r[6:0], 1'b0};
        end
        if (clkRise) begin
          shift_r <= byteNow;
          bitCnt_r <= bitCnt_r + 3'd1;
          if (state_r == ST_OUT && bitCnt_r == 3'd7) begin
            // alternate the two id bytes for as long as clocks continue
            outShift_r <= (idSel_r ^ idSecond_r) ? MAKER_ID : PART_ID;
            idSecond_r <= !idSecond_r;
          end
        end
        if (byteDone) begin
          oneByte_r <= 1'b0;
          case (state_r)
            ST_OP: begin
              op_r <= byteNow;
              byteCnt_r <= 3'd0;
              if (sleepMode && byteNow != `OP_SIG_READ) begin
                state_r <= ST_IGNORE;
              end else if (!knownOp(byteNow)) begin
                state_r <= ST_IGNORE;
                op_r <= 8'h00;
              end else if (needsAddr(byteNow)) begin
                state_r <= ST_ADDR;
              end else begin
                state_r <= ST_DATA;
                oneByte_r <= 1'b1;
              end
            end
            ST_ADDR: begin
              cmdAddr <= {cmdAddr[15:0], byteNow};
              byteCnt_r <= byteCnt_r + 3'd1;
              if (op_r == `OP_ID_READ && byteCnt_r == `ID_SKIP_BYTES) begin
                idSel_r <= byteNow[0];
                idSecond_r <= 1'b0;
                outShift_r <= byteNow[0] ? PART_ID : MAKER_ID;
                state_r <= ST_OUT;
              end else if (byteCnt_r == `ADDR_BYTES - 3'd1) begin
                if (op_r == `OP_PARAM_READ || op_r == `OP_DUAL_READ) state_r <= ST_DUMMY;
                else state_r <= ST_DATA;
              end
            end
            ST_DUMMY: begin
              state_r <= ST_DATA;
            end
            default: begin
              state_r <= state_r;
            end
          endcase
        end
      end
    end
  end
endmodule

// small valid/ready fifo for captured bytes; pointers carry one extra wrap bit
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  // depth must be two to the power aw, full and empty rely on the wrap bit
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire empty = wrPtr_r == rdPtr_r;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always @(posedge clk) begin
    if (inValid && !full) mem[wrPtr_r[AW-1:0]] <= inData;
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) wrPtr_r <= wrPtr_r + 1'b1;
      if (outReady && !empty) rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule

// ### sim/flash_cmd_monitor.sv
// port-level assertions for the flash command interpreter
`timescale 1ns/1ps
module flash_cmd_monitor (
  input wire clk,
  input wire rst_b,
  input wire selB,
  input wire serOutEn,
  input wire writeLatchBit,
  input wire otpMode,
  input wire lockBit,
  input wire sleepMode,
  input wire cmdPulse,
  input wire dataValid,
  input wire dataReady,
  input wire dataStall
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_deselected;
    selB [*8];
  endsequence
  sequence s_done;
    cmdPulse ##1 !cmdPulse;
  endsequence
  a_lock_never_clears: assert property (lockBit |=> lockBit) else $error("lock bit cleared");
  a_lock_sets_quiet: assert property ($rose(lockBit) |-> $past(selB, 2)) else $error("lock set mid frame");
  a_arm_after_frame: assert property ($rose(writeLatchBit) |-> $past(selB, 2)) else $error("latch set mid frame");
  a_otp_change_quiet: assert property ($changed(otpMode) |-> $past(selB, 2)) else $error("otp mode mid frame");
  a_sleep_change_quiet: assert property ($changed(sleepMode) |-> $past(selB, 2)) else $error("sleep mid frame");
  a_pulse_single_clk: assert property (cmdPulse |-> s_done) else $error("completion pulse too long");
  a_pulse_clears_latch: assert property (cmdPulse |-> ##[0:2] !writeLatchBit) else $error("latch kept");
  a_pulse_needs_arm: assert property (cmdPulse |-> $past(writeLatchBit)) else $error("modify while unarmed");
  a_idle_no_drive: assert property (s_deselected |=> !serOutEn) else $error("driving while deselected");
  a_full_not_empty: assert property (dataStall |-> dataValid) else $error("full yet empty");
  a_full_holds: assert property (dataStall && !dataReady |=> dataStall) else $error("full fifo lost a word");
endmodule
bind spi_flash_cmd_write_latch flash_cmd_monitor i_mon (.clk(clk), .rst_b(rst_b), .selB(selB), .serOutEn(serOutEn),
  .writeLatchBit(writeLatchBit), .otpMode(otpMode), .lockBit(lockBit), .sleepMode(sleepMode), .cmdPulse(cmdPulse),
  .dataValid(dataValid), .dataReady(dataReady), .dataStall(dataStall));

// ### sim/spi_host.sv
// serial host model: select, clock and data toward the flash block
`timescale 1ns/1ps
module spi_host (
  input wire clk,
  output logic selB,
  output logic serClk,
  output logic serIn,
  input wire serOut
);
  initial begin
    selB = 1'b1;
    serClk = 1'b0;
    serIn = 1'b0;
  end
  // 10 clk half period gives the 80 ns link clock
  task automatic half();
    repeat (10) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serIn = tx[i];
      half();
      serClk = 1'b1;
      rx[i] = serOut;
      half();
      serClk = 1'b0;
    end
  endtask
  // select rises only on a byte boundary; clock stands low outside frames
  task automatic frame(input logic [7:0] b[$], output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    selB = 1'b0;
    half();
    foreach (b[k]) begin
      xfer(b[k], r);
      rx.push_back(r);
    end
    half();
    selB = 1'b1;
    // released data line has no pull: show a fresh level
    serIn = ~serIn;
    half();
  endtask
endmodule

// ### sim/spi_flash_cmd_write_latch_tb.sv
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
module spi_flash_cmd_write_latch_tb;
  // arbitrary identity values
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] PART = 8'hE7;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic dataReady = 1'b0;
  wire selB, serClk, serIn, serOut, serOutEn, writeLatchBit, otpMode, lockBit, sleepMode, cmdPulse;
  wire dataValid, dataStall;
  wire [7:0] cmdCode, dataByte;
  wire [23:0] cmdAddr;
  int n_fail = 0;
  int total_checks = 0;
  int nPulse = 0;
  logic [7:0] rx[$];
  always #2 clk = ~clk;
  always @(posedge clk) if (cmdPulse === 1'b1) nPulse++;
  spi_flash_cmd_write_latch #(.MAKER_ID(MAKER), .PART_ID(PART), .FIFO_DEPTH(8)) i_dut (.clk(clk), .rst_b(rst_b),
    .selB(selB), .serClk(serClk), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn), .writeLatchBit(writeLatchBit),
    .otpMode(otpMode), .lockBit(lockBit), .sleepMode(sleepMode), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
    .cmdPulse(cmdPulse), .dataByte(dataByte), .dataValid(dataValid), .dataReady(dataReady), .dataStall(dataStall));
  spi_host i_host (.clk(clk), .selB(selB), .serClk(serClk), .serIn(serIn), .serOut(serOut));
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] b[$]);
    i_host.frame(b, rx);
  endtask
  task automatic t_latch();
    chk(writeLatchBit, 1'b0, "latch after reset");
    run('{8'h06});
    chk(writeLatchBit, 1'b1, "arm");
    // undefined opcode sent on purpose
    run('{8'hFF, 8'h00});
    chk(writeLatchBit, 1'b1, "unknown opcode");
    run('{8'h04});
    chk(writeLatchBit, 1'b0, "disarm");
  endtask
  task automatic t_modify();
    logic [7:0] ops[6] = '{8'h20, 8'h52, 8'hD8, 8'h02, 8'h60, 8'hC7};
    int p;
    foreach (ops[k]) begin
      p = nPulse;
      run('{8'h06});
      if (k < 4)
        run('{ops[k], 8'h12, 8'h34, 8'h56});
      else
        run('{ops[k]});
      chk(nPulse - p, 1, "one completion");
      chk(cmdCode, ops[k], "opcode");
      chk(writeLatchBit, 1'b0, "latch after modify");
      if (k < 4)
        chk(cmdAddr, 24'h12_3456, "address");
    end
    p = nPulse;
    run('{8'h20, 8'h00, 8'h00, 8'h00});
    chk(nPulse - p, 0, "unarmed wipe");
  endtask
  task automatic t_fifo();
    logic [7:0] b[$] = '{8'h02, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 10; i++) b.push_back(8'hC0 + i[7:0]);
    run('{8'h06});
    run(b);
    chk(dataStall, 1'b1, "fifo full");
    run('{8'h06});
    run('{8'h01, 8'h00});
    chk(writeLatchBit, 1'b0, "status write");
    for (int i = 0; i < 8; i++) begin
      chk(dataByte, 8'hC0 + i[7:0], "fifo data");
      dataReady = 1'b1;
      @(negedge clk);
      dataReady = 1'b0;
      @(negedge clk);
    end
    chk(dataValid, 1'b0, "fifo drained");
  endtask
  task automatic t_reads();
    logic [7:0] ops[2] = '{8'h5A, 8'h3B};
    int p = nPulse;
    run('{8'h06});
    foreach (ops[k]) begin
      run('{ops[k], 8'h0A, 8'h0B, 8'h0C + k[7:0], 8'hEE, 8'h70 + k[7:0]});
      chk(cmdAddr, 24'h0A_0B0C + k, "read address");
      chk(dataByte, 8'h70 + k[7:0], "byte after dummy");
      dataReady = 1'b1;
      @(negedge clk);
      dataReady = 1'b0;
      @(negedge clk);
      chk(dataValid, 1'b0, "dummy byte kept");
    end
    run('{8'h2B});
    chk(writeLatchBit, 1'b1, "reads keep latch");
    chk(nPulse - p, 0, "read completed a modify");
  endtask
  task automatic t_id();
    for (int o = 0; o < 2; o++) begin
      i_host.frame('{8'h90, 8'h00, 8'h00, o[7:0], 8'h00, 8'h00}, rx);
      chk(rx[4], o ? PART : MAKER, "first id");
      chk(rx[5], o ? MAKER : PART, "second id");
    end
  endtask
  task automatic t_modes();
    run('{8'hB1});
    chk(otpMode, 1'b1, "otp open");
    run('{8'hC1});
    chk(otpMode, 1'b0, "otp close");
    run('{8'h06});
    run('{8'h2F});
    chk(lockBit, 1'b1, "lock set");
    run('{8'h06});
    run('{8'h04});
    chk(lockBit, 1'b1, "lock kept");
    run('{8'hB9});
    chk(sleepMode, 1'b1, "sleep");
    run('{8'h06});
    chk(writeLatchBit, 1'b0, "arm while asleep");
    run('{8'hAB});
    chk(sleepMode, 1'b0, "wake");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    t_latch();
    t_modify();
    t_fifo();
    t_reads();
    t_id();
    t_modes();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
